/* design/sfm_regs.sv */
// Purpose: Area fill flags, asynchronous done timeout and per-bank memory read pointers.
// Assumes: Synchronous active-high reset; all inputs synchronous to core_clk.
// Notes:   The scheduler proper sits outside; this block tells it which area to walk.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Async flag set means walk async area.
// - Periodic flag set means walk periodic area.
// - Isochronous flag set means walk isochronous area.
// - Cleared flag skips that area entirely.
// - Walk only valid, non-skipped descriptor headers.
// - 32-bit timeout in ms raises interrupt.
// - Timeout covers completed async descriptors only.
// - Bank pointer latched, increments on each PIO read while dma_active is low.
// - Bits 17:16 select one of four banks.
// - Bank select affects programmed I/O only.
// - Bits 15:0 give the start read address.
module sfm_regs
    import sfm_pkg::*;
#(
    parameter int CYC_PER_MS = SFM_CYC_PER_MS,
    parameter int NUM_BANKS = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire sfm_req_t reg_req,
    output logic [31:0] reg_rdata,
    input wire sfm_mem_rd_t pio_rd,
    input wire logic dma_active,
    output logic [15:0] pio_rd_addr,
    output logic [1:0] pio_rd_bank,
    input wire logic hdr_valid,
    input wire logic hdr_skip,
    input wire logic hdr_next,
    output logic hdr_take,
    output logic [1:0] walk_area,
    input wire logic async_done,
    input wire logic int_enable,
    output logic timeout_irq
);

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    function automatic logic hit(input sfm_req_t r, input logic [11:0] ofs);
        return r.addr == ofs;
    endfunction

    logic [2:0] fill_q, fill_d;
    logic [31:0] tmo_q, tmo_d;
    logic [15:0] ptr_q [NUM_BANKS];
    logic [15:0] ptr_d [NUM_BANKS];
    logic [1:0] bank_q, bank_d;

    // Flags and timeout value; reserved bits are dropped so they read zero.
    always_comb begin
        fill_d = fill_q;
        tmo_d = tmo_q;
        if (reg_req.wr && hit(reg_req, SFM_FILL_OFS)) begin
            fill_d = reg_req.wdata[2:0];
        end
        if (reg_req.wr && hit(reg_req, SFM_TMO_OFS)) begin
            tmo_d = reg_req.wdata;
        end
    end

    // Pointers: a write loads the selected bank; a PIO read advances only its own bank.
    // DMA traffic never touches these pointers.
    always_comb begin
        bank_d = bank_q;
        for (int i = 0; i < NUM_BANKS; i++) begin
            ptr_d[i] = ptr_q[i];
        end
        if (pio_rd.rd && !dma_active) begin
            ptr_d[pio_rd.bank] = ptr_q[pio_rd.bank] + 16'h0001;
        end
        // A fresh start address wins over an increment in the same cycle.
        if (reg_req.wr && hit(reg_req, SFM_MEM_OFS)) begin
            bank_d = reg_req.wdata[SFM_BANK_LSB +: 2];
            ptr_d[reg_req.wdata[SFM_BANK_LSB +: 2]] = reg_req.wdata[SFM_ADDR_LSB +: 16];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fill_q <= SFM_FILL_RST;
            tmo_q <= SFM_TMO_RST;
            bank_q <= 2'h0;
            for (int i = 0; i < NUM_BANKS; i++) begin
                ptr_q[i] <= SFM_ADDR_RST;
            end
        end else begin
            fill_q <= fill_d;
            tmo_q <= tmo_d;
            bank_q <= bank_d;
            for (int i = 0; i < NUM_BANKS; i++) begin
                ptr_q[i] <= ptr_d[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Read-back and PIO address outputs
    // ------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [15:0] addr_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                SFM_FILL_OFS: rdata_d = {29'h0, fill_q};
                SFM_TMO_OFS: rdata_d = tmo_q;
                SFM_MEM_OFS: rdata_d = {14'h0, bank_q, ptr_q[bank_q]};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        addr_d = ptr_d[pio_rd.bank];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
            pio_rd_addr <= SFM_ADDR_RST;
            pio_rd_bank <= 2'h0;
        end else begin
            reg_rdata <= rdata_d;
            pio_rd_addr <= addr_d;
            pio_rd_bank <= pio_rd.bank;
        end
    end

    // ------------------------------------------------------------
    // Area walk: async, periodic, isochronous in turn, skipping empty areas.
    // ------------------------------------------------------------
    sfm_walk_t walk_q, walk_d;
    logic take_d;

    function automatic sfm_walk_t next_area(input sfm_walk_t cur, input logic [2:0] f);
        sfm_walk_t n;
        n = SFM_IDLE;
        unique case (cur)
            SFM_IDLE: n = f[SFM_ASYNC_BIT] ? SFM_ASYNC : f[SFM_PERIODIC_BIT] ? SFM_PERIODIC :
                          f[SFM_ISO_BIT] ? SFM_ISO : SFM_IDLE;
            SFM_ASYNC: n = f[SFM_PERIODIC_BIT] ? SFM_PERIODIC : f[SFM_ISO_BIT] ? SFM_ISO : SFM_IDLE;
            SFM_PERIODIC: n = f[SFM_ISO_BIT] ? SFM_ISO : SFM_IDLE;
            SFM_ISO: n = SFM_IDLE;
        endcase
        return n;
    endfunction

    // An area whose flag drops mid-walk is abandoned at once.
    always_comb begin
        walk_d = walk_q;
        take_d = 1'b0;
        unique case (walk_q)
            SFM_IDLE: walk_d = next_area(SFM_IDLE, fill_q);
            SFM_ASYNC: if (!fill_q[SFM_ASYNC_BIT] || hdr_next) begin
                walk_d = next_area(SFM_ASYNC, fill_q);
            end
            SFM_PERIODIC: if (!fill_q[SFM_PERIODIC_BIT] || hdr_next) begin
                walk_d = next_area(SFM_PERIODIC, fill_q);
            end
            SFM_ISO: if (!fill_q[SFM_ISO_BIT] || hdr_next) begin
                walk_d = next_area(SFM_ISO, fill_q);
            end
        endcase
        if (walk_q != SFM_IDLE && hdr_valid && !hdr_skip) begin
            take_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            walk_q <= SFM_IDLE;
            hdr_take <= 1'b0;
            walk_area <= SFM_IDLE;
        end else begin
            walk_q <= walk_d;
            hdr_take <= take_d;
            walk_area <= walk_d;
        end
    end

    // ------------------------------------------------------------
    // Async done timeout: counts ms from the first unreported completion.
    // A zero timeout disables the timer rather than firing at once.
    // ------------------------------------------------------------
    logic [31:0] cyc_q, cyc_d;
    logic [31:0] ms_q, ms_d;
    logic pend_q, pend_d;
    logic irq_d;

    always_comb begin
        cyc_d = cyc_q;
        ms_d = ms_q;
        pend_d = pend_q | async_done;
        irq_d = 1'b0;
        if (!pend_q || tmo_q == 32'h0000_0000) begin
            cyc_d = 32'h0000_0000;
            ms_d = 32'h0000_0000;
        end else if (cyc_q == 32'(CYC_PER_MS - 1)) begin
            cyc_d = 32'h0000_0000;
            ms_d = ms_q + 32'h0000_0001;
        end else begin
            cyc_d = cyc_q + 32'h0000_0001;
        end
        if (pend_q && tmo_q != 32'h0000_0000 && ms_q == tmo_q) begin
            irq_d = int_enable;
            pend_d = async_done;
            cyc_d = 32'h0000_0000;
            ms_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cyc_q <= 32'h0000_0000;
            ms_q <= 32'h0000_0000;
            pend_q <= 1'b0;
            timeout_irq <= 1'b0;
        end else begin
            cyc_q <= cyc_d;
            ms_q <= ms_d;
            pend_q <= pend_d;
            timeout_irq <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_fill_skip: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_q == SFM_ASYNC && !fill_q[SFM_ASYNC_BIT] |=> walk_q != SFM_ASYNC)
        else $error("async area walked with empty flag");
    chk_async_walk: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_q == SFM_IDLE && fill_q[SFM_ASYNC_BIT] |=> walk_q == SFM_ASYNC)
        else $error("async area not entered");
    chk_periodic_walk: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_q == SFM_IDLE && fill_q == 3'h2 |=> walk_q == SFM_PERIODIC)
        else $error("periodic area not entered");
    chk_iso_walk: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_q == SFM_IDLE && fill_q == 3'h4 |=> walk_q == SFM_ISO)
        else $error("iso area not entered");
    chk_hdr_take: assert property (@(posedge core_clk) disable iff (sys_rst)
        hdr_take |-> $past(hdr_valid) && !$past(hdr_skip) && $past(walk_q) != SFM_IDLE)
        else $error("invalid or skipped header taken");
    chk_tmo_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_req.wr && reg_req.addr == SFM_TMO_OFS |=> tmo_q == $past(reg_req.wdata))
        else $error("timeout value not stored");
    chk_irq_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
        timeout_irq |-> $past(pend_q) && $past(ms_q) == $past(tmo_q) && $past(int_enable))
        else $error("timeout interrupt without async completion");
    chk_ptr_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_req.wr && reg_req.addr == SFM_MEM_OFS |=>
            ptr_q[$past(reg_req.wdata[17:16])] == $past(reg_req.wdata[15:0]))
        else $error("start address not latched");
    chk_ptr_incr: assert property (@(posedge core_clk) disable iff (sys_rst)
        pio_rd.rd && !dma_active && !reg_req.wr |=>
            ptr_q[$past(pio_rd.bank)] == $past(ptr_q[pio_rd.bank]) + 16'h0001)
        else $error("pointer did not advance on read");
    chk_dma_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        dma_active && pio_rd.rd && !reg_req.wr |=>
            ptr_q[$past(pio_rd.bank)] == $past(ptr_q[pio_rd.bank]))
        else $error("dma moved a pio pointer");

    cov_async: cover property (@(posedge core_clk) disable iff (sys_rst) walk_q == SFM_ASYNC);
    cov_irq: cover property (@(posedge core_clk) disable iff (sys_rst) timeout_irq);
    cov_incr: cover property (@(posedge core_clk) disable iff (sys_rst) pio_rd.rd ##1 pio_rd.rd);

endmodule // sfm_regs

`default_nettype wire

/* include/sfm_pkg.sv */
// Purpose: Shared constants and types for the schedule fill and memory read register bank.
// Assumes: Word-wide register port with byte addresses; 40 MHz core clock.
// Notes:   Offsets, field positions, reset values and cycle counts live here only.
package sfm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] SFM_FILL_OFS = 12'h334;
    localparam logic [11:0] SFM_TMO_OFS = 12'h338;
    localparam logic [11:0] SFM_MEM_OFS = 12'h33c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SFM_ASYNC_BIT = 0;
    localparam int SFM_PERIODIC_BIT = 1;
    localparam int SFM_ISO_BIT = 2;
    localparam int SFM_BANK_LSB = 16;
    localparam int SFM_ADDR_LSB = 0;
    localparam logic [2:0] SFM_FILL_RST = 3'h0;
    localparam logic [31:0] SFM_TMO_RST = 32'h0000_0000;
    localparam logic [15:0] SFM_ADDR_RST = 16'h0000;

    // ------------------------------------------------------------
    // Timing: one millisecond in core clock cycles.
    // ------------------------------------------------------------
    localparam int SFM_CLK_KHZ = 40000;
    localparam int SFM_MS_PER_TICK = 1;
    localparam int SFM_CYC_PER_MS = SFM_CLK_KHZ * SFM_MS_PER_TICK;

    // Register access request carried as one bundle.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } sfm_req_t;

    // Programmed memory read strobe from the data port.
    typedef struct packed {
        logic rd;
        logic [1:0] bank;
    } sfm_mem_rd_t;

    typedef enum logic [1:0] {
        SFM_IDLE = 2'b00,
        SFM_ASYNC = 2'b01,
        SFM_PERIODIC = 2'b11,
        SFM_ISO = 2'b10
    } sfm_walk_t;

endpackage

/* test/sfm_host_model.sv */
// Purpose: Host processor model that drives the register port and the PIO read strobe.
// Assumes: Each request is launched just after a rising edge and lasts one cycle.
// Notes:   Reserved bits of the fill and memory registers always go out as zero; unmapped offsets pass whole.
`timescale 1ns/100ps
`default_nettype none

module sfm_host_model
    import sfm_pkg::*;
(
    input wire logic core_clk,
    input wire logic [31:0] reg_rdata,
    output var sfm_req_t reg_req,
    output var sfm_mem_rd_t pio_rd
);

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // The bus is idle from time zero, so nothing is requested during reset.
    initial begin
        reg_req = '0;
        pio_rd = '0;
    end

    // Keeps reserved bits at their reset value of zero; unmapped places are left whole.
    function automatic logic [31:0] rsv_mask(input logic [11:0] a);
        case (a)
            SFM_FILL_OFS: return 32'h0000_0007;
            SFM_MEM_OFS: return 32'h0003_ffff;
            default: return 32'hffff_ffff;
        endcase
    endfunction

    // One write; flags may be set right after reset, as at initialisation.
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{1'b1, 1'b0, a, d & rsv_mask(a)};
        @(posedge core_clk);
        reg_req <= '0;
    endtask

    // One read; the data is registered at the edge that takes the strobe.
    task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        d = reg_rdata;
    endtask

    // One programmed memory read; only the start address is ever written first.
    // The bank stays on the port after the strobe, so the address output keeps showing that bank.
    task automatic mem_rd(input logic [1:0] b);
        @(posedge core_clk);
        pio_rd <= '{1'b1, b};
        @(posedge core_clk);
        pio_rd.rd <= 1'b0;
    endtask

endmodule // sfm_host_model
`default_nettype wire

/* test/tb.sv */
// Purpose: Self-checking bench for the fill flags, done timeout and read pointers.
// Assumes: The ms prescale is shortened to 4 cycles so timeouts stay short.
// Notes:   Scheduler-side inputs are driven here; the host model owns the bus.
`timescale 1ns/100ps
`default_nettype none

module tb;
    import sfm_pkg::*;
    localparam int CPM = 4;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic dma_active = 1'b0, hdr_valid = 1'b0, hdr_skip = 1'b0, hdr_next = 1'b0;
    logic async_done = 1'b0, int_enable = 1'b0;
    sfm_req_t reg_req;
    sfm_mem_rd_t pio_rd;
    logic [31:0] reg_rdata, rd_v;
    logic [15:0] pio_rd_addr;
    logic [1:0] pio_rd_bank, walk_area;
    logic hdr_take, timeout_irq;
    int errors = 0;
    int cmp_count = 0;
    int c, f;
    logic [2:0] fills [6] = '{3'h1, 3'h4, 3'h0, 3'h2, 3'h0, 3'h4};
    logic [1:0] areas [6] = '{2'b01, 2'b10, 2'b00, 2'b11, 2'b00, 2'b10};

    always #12.5 core_clk = ~core_clk;

    // Completion and end-of-area strobes last exactly one cycle.
    always @(posedge core_clk) begin
        if (async_done) async_done <= 1'b0;
        if (hdr_next) hdr_next <= 1'b0;
    end

    sfm_host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req), .pio_rd(pio_rd));

    sfm_regs #(.CYC_PER_MS(CPM), .NUM_BANKS(4)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .pio_rd(pio_rd), .dma_active(dma_active), .pio_rd_addr(pio_rd_addr), .pio_rd_bank(pio_rd_bank),
        .hdr_valid(hdr_valid), .hdr_skip(hdr_skip), .hdr_next(hdr_next), .hdr_take(hdr_take),
        .walk_area(walk_area), .async_done(async_done), .int_enable(int_enable), .timeout_irq(timeout_irq));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        host.reg_rd(a, rd_v);
        chk_val("reg_rdata", e, rd_v);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Counts high cycles of the take pulse or the interrupt, and the first one seen.
    task automatic count(input bit irq, input int n, output int cnt, output int first);
        cnt = 0;
        first = -1;
        for (int i = 1; i <= n; i++) begin
            @(posedge core_clk);
            #1;
            if ((irq ? timeout_irq : hdr_take) === 1'b1) begin
                if (first < 0) first = i;
                cnt++;
            end
        end
    endtask

    // A bounded wait guards against a pointer that never moves.
    task automatic pio_chk(input logic [1:0] b, input logic [15:0] e);
        int i;
        i = 0;
        host.mem_rd(b);
        #1;
        while (i < 6 && pio_rd_addr !== e) begin
            cyc(1);
            i++;
        end
        if (i == 6) begin
            errors++;
            report_and_stop();
        end else begin
            chk_val("pio_rd_addr", {16'h0, e}, {16'h0, pio_rd_addr});
            chk_val("pio_rd_bank", {30'h0, b}, {30'h0, pio_rd_bank});
        end
    endtask

    // A hung design still ends the run with a verdict.
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk(SFM_FILL_OFS, 32'h0);
        rchk(SFM_TMO_OFS, 32'h0);
        rchk(SFM_MEM_OFS, 32'h0);
        host.reg_wr(12'h340, 32'hffff_ffff);
        rchk(12'h340, 32'h0);
        for (int j = 0; j < 6; j++) begin
            host.reg_wr(SFM_FILL_OFS, {29'h0, fills[j]});
            cyc(3);
            chk_val("walk_area", {30'h0, areas[j]}, {30'h0, walk_area});
        end
        host.reg_wr(SFM_FILL_OFS, 32'h3);
        rchk(SFM_FILL_OFS, 32'h3);
        @(posedge core_clk) {hdr_valid, hdr_skip} <= 2'b11;
        count(1'b0, 6, c, f);
        chk_val("hdr_take skipped", 32'h0, c);
        @(posedge core_clk) hdr_skip <= 1'b0;
        count(1'b0, 6, c, f);
        chk_val("hdr_take valid", 32'h1, {31'h0, c > 0});
        @(posedge core_clk) {hdr_valid, hdr_next} <= 2'b01;
        cyc(3);
        chk_val("walk_area", 32'h3, {30'h0, walk_area});
        host.reg_wr(SFM_FILL_OFS, 32'h0);
        host.reg_wr(SFM_MEM_OFS, 32'h0002_0010);
        rchk(SFM_MEM_OFS, 32'h0002_0010);
        pio_chk(2'h2, 16'h0011);
        pio_chk(2'h2, 16'h0012);
        host.reg_wr(SFM_MEM_OFS, 32'h0001_0100);
        pio_chk(2'h2, 16'h0013);
        pio_chk(2'h3, 16'h0001);
        rchk(SFM_MEM_OFS, 32'h0001_0100);
        @(posedge core_clk) dma_active <= 1'b1;
        host.mem_rd(2'h1);
        @(posedge core_clk) dma_active <= 1'b0;
        rchk(SFM_MEM_OFS, 32'h0001_0100);
        pio_chk(2'h1, 16'h0101);
        host.reg_wr(SFM_TMO_OFS, 32'h3);
        rchk(SFM_TMO_OFS, 32'h3);
        @(posedge core_clk) int_enable <= 1'b1;
        count(1'b1, 40, c, f);
        chk_val("irq without completion", 32'h0, c);
        @(posedge core_clk) async_done <= 1'b1;
        count(1'b1, 40, c, f);
        chk_val("irq pulses", 32'h1, c);
        chk_val("irq delay", 32'h1, {31'h0, f >= 3 * CPM - 1 && f <= 3 * CPM + 3});
        @(posedge core_clk) {int_enable, async_done} <= 2'b01;
        count(1'b1, 40, c, f);
        chk_val("irq disabled", 32'h0, c);
        report_and_stop();
    end

endmodule // tb
`default_nettype wire
